/* rtl/escap_params.svh */
// Offsets, field positions, reset values and counts of the sample capture block.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef ESCAP_PARAMS_SVH
`define ESCAP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ESCAP_OFS_CMD      8'h00
`define ESCAP_OFS_CONFIG   8'h04
`define ESCAP_OFS_COUPLING 8'h08
`define ESCAP_OFS_STATUS   8'h0C
`define ESCAP_OFS_RESULT0  8'h10
`define ESCAP_OFS_RESULT1  8'h14
`define ESCAP_OFS_RESULT2  8'h18
`define ESCAP_OFS_RESULT3  8'h1C

// ----------------------------------------------------------------------------
// Command register bits (write only, reads zero)
// ----------------------------------------------------------------------------
`define ESCAP_CMD_ARM_BIT   0
`define ESCAP_CMD_MODE_BIT  1
`define ESCAP_CMD_CLEAR_BIT 2
`define ESCAP_CMD_READ_BIT  3

// ----------------------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------------------
`define ESCAP_CFG_COUNT_LSB 0
`define ESCAP_CFG_BASE_LSB  4
`define ESCAP_CFG_EXT_BIT   8

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define ESCAP_ST_ARMED_BIT  0
`define ESCAP_ST_BUSY_BIT   1
`define ESCAP_ST_EMPTY_BIT  2
`define ESCAP_ST_OVF_BIT    3
`define ESCAP_ST_LEVEL_LSB  16

// ----------------------------------------------------------------------------
// Sizes, codes and reset values
// ----------------------------------------------------------------------------
`define ESCAP_FIFO_DEPTH    1024
`define ESCAP_ARM_MODE_ARM  1'b0
`define ESCAP_COUPLE_AC     2'h0
`define ESCAP_COUPLE_DC     2'h1
`define ESCAP_COUPLE_GND    2'h2
`define ESCAP_RST_COUNT4    3'h4
`define ESCAP_RST_COUNT2    3'h2
`define ESCAP_RST_BASE      2'h0

`endif

/* rtl/escap_pkg.sv */
// Types shared by the sample capture block.
// Assumes the constants of escap_params.svh.
package escap_pkg;

  typedef enum logic [1:0] {
    ESCAP_V12,
    ESCAP_V16_2CH,
    ESCAP_V16_4CH
  } escap_variant_e;

  typedef struct packed {
    logic       ext_sel;
    logic [1:0] base;
    logic [2:0] count;
  } escap_cfg_s;

  typedef logic [15:0] escap_sample_t;

endpackage : escap_pkg

/* rtl/escap_top.sv */
// Externally clocked simultaneous sample capture with sample FIFO, APB slave.
// Assumes APB master on mclk_in; capture pins are synchronous to mclk_in.
//
// Contract
// - Arm command mode 0 arms external capture, mode 1 disarms it.
// - Arm command empties the sample FIFO before any new sample.
// - Armed, each rising edge of sample clock pin captures selected channels.
// - Armed, each falling edge of bus clock input also captures them.
// - Armed external read returns oldest stored sample set, FIFO order.
// - Armed external read on empty FIFO flags error, returns nothing.
// - Clear, any time, empties FIFO and clears latched error flags.
// - Samples lost to a full FIFO set overflow until clear.
// - One channel external: read takes two samples, earlier first.
// - Without external clock, read samples inputs at command time.
// - Read returns one sample per selected channel, two for one channel external.
// - 12-bit variant results are sign-extended, -2048 to +2047.
// - 16-bit variants results are two's complement, full 16 bits.
// - Coupling code 0 AC, 1 DC, 2 ground.
// - Programmable inputs: 5, 2 or 4 depending on variant.
// - Reset coupling: AC on 12-bit, DC on 16-bit variants.
// - Reset selects every input channel.
// - FIFO holds 1024 results.
`timescale 1ns/1ps
`include "escap_params.svh"
`default_nettype none

module escap_top
  import escap_pkg::*;
#(
  parameter escap_variant_e VARIANT = ESCAP_V12
)
(
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        ext_sample_clock_n_in,
  input  wire logic        bus_clock_input_in,
  input  wire logic [63:0] adc_data_in,
  output logic             hold_out,
  output logic      [4:0]  couple_dc_out,
  output logic      [4:0]  couple_gnd_out
);

  localparam int DEPTH = `ESCAP_FIFO_DEPTH;
  localparam int NPROG = (VARIANT == ESCAP_V12) ? 5 :
                         (VARIANT == ESCAP_V16_2CH) ? 2 : 4;
  localparam logic [1:0] RST_COUPLE = (VARIANT == ESCAP_V12) ?
                         `ESCAP_COUPLE_AC : `ESCAP_COUPLE_DC;
  localparam logic [2:0] RST_COUNT = (VARIANT == ESCAP_V16_2CH) ?
                         `ESCAP_RST_COUNT2 : `ESCAP_RST_COUNT4;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic        wr;
  logic        rd_setup;
  logic        cmd_hit;
  logic        arm_capture_cmd;
  logic        fifo_clear_cmd;
  logic        sample_read_cmd;
  logic        flush;
  logic        mapped;

  assign wr              = psel_in & penable_in & pwrite_in;
  assign rd_setup        = psel_in & ~penable_in;
  assign cmd_hit         = wr && (paddr_in == `ESCAP_OFS_CMD);
  assign arm_capture_cmd = cmd_hit & pwdata_in[`ESCAP_CMD_ARM_BIT];
  assign fifo_clear_cmd  = cmd_hit & pwdata_in[`ESCAP_CMD_CLEAR_BIT];
  assign sample_read_cmd = cmd_hit & pwdata_in[`ESCAP_CMD_READ_BIT];
  assign flush           = fifo_clear_cmd | arm_capture_cmd;
  assign mapped          = (paddr_in[1:0] == 2'h0) &&
                           (paddr_in <= `ESCAP_OFS_RESULT3);
  assign pready_out      = 1'b1;

  // --------------------------------------------------------------------------
  // Configuration and coupling
  // --------------------------------------------------------------------------
  escap_cfg_s  cfg;
  logic [9:0]  coupling;
  logic [9:0]  couple_mask;
  logic        armed;
  logic        ext_active;

  assign couple_mask = 10'((1 << (2 * NPROG)) - 1);
  assign ext_active  = armed & cfg.ext_sel;

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      cfg.count   <= RST_COUNT;
      cfg.base    <= `ESCAP_RST_BASE;
      cfg.ext_sel <= 1'b0;
    end
    else if (wr && paddr_in == `ESCAP_OFS_CONFIG)
    begin
      cfg.count   <= pwdata_in[`ESCAP_CFG_COUNT_LSB +: 3];
      cfg.base    <= pwdata_in[`ESCAP_CFG_BASE_LSB +: 2];
      cfg.ext_sel <= pwdata_in[`ESCAP_CFG_EXT_BIT];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      coupling <= {5{RST_COUPLE}} & couple_mask;
    else if (wr && paddr_in == `ESCAP_OFS_COUPLING)
      coupling <= pwdata_in[9:0] & couple_mask;
  end

  // Ground switch is absent on the 12-bit variant, so code 2 cannot ground
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_couple
      always_ff @(posedge mclk_in)
      begin
        if (!reset_n_in)
        begin
          couple_dc_out[gi]  <= 1'b0;
          couple_gnd_out[gi] <= 1'b0;
        end
        else
        begin
          couple_dc_out[gi]  <= (coupling[2*gi +: 2] ==
                                 `ESCAP_COUPLE_DC);
          couple_gnd_out[gi] <= (coupling[2*gi +: 2] ==
                                 `ESCAP_COUPLE_GND) &&
                                (VARIANT != ESCAP_V12);
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      armed <= 1'b0;
    else if (arm_capture_cmd)
      armed <= (pwdata_in[`ESCAP_CMD_MODE_BIT] ==
                `ESCAP_ARM_MODE_ARM);
  end

  // --------------------------------------------------------------------------
  // Capture edges
  // --------------------------------------------------------------------------
  logic        sclk_q;
  logic        bclk_q;
  logic        capture_ev;

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      sclk_q <= 1'b1;
      bclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= ext_sample_clock_n_in;
      bclk_q <= bus_clock_input_in;
    end
  end

  assign capture_ev = ext_active & ~flush &
                      ((ext_sample_clock_n_in & ~sclk_q) |
                       (~bus_clock_input_in & bclk_q));

  function automatic escap_sample_t fmt(input escap_sample_t raw);
    if (VARIANT == ESCAP_V12)
      fmt = {{4{raw[11]}}, raw[11:0]};
    else
      fmt = raw;
  endfunction : fmt

  // --------------------------------------------------------------------------
  // Sample FIFO
  // --------------------------------------------------------------------------
  escap_sample_t mem [DEPTH];
  logic [9:0]    wptr;
  logic [9:0]    rptr;
  logic [10:0]   level;
  logic [10:0]   next_level;
  logic          do_push;
  logic          do_pop;
  logic          full;
  escap_sample_t snap [4];
  logic [2:0]    push_left;
  logic [1:0]    push_idx;
  logic [2:0]    pop_left;
  logic [1:0]    pop_idx;
  logic [2:0]    need;
  logic          lost;

  assign full    = (level == 11'(DEPTH));
  assign do_push = (push_left != 3'h0) & ~full & ~flush;
  assign do_pop  = (pop_left != 3'h0) & ~flush;
  assign lost    = ((push_left != 3'h0) & full & ~flush) |
                   (capture_ev & (push_left != 3'h0));
  // Single channel is stored one result per edge and read in pairs
  assign need    = (cfg.count == 3'h1) ? 3'h2 : cfg.count;

  always_comb
  begin
    next_level = level;
    if (do_push && !do_pop)
      next_level = level + 11'h1;
    else if (do_pop && !do_push)
      next_level = level - 11'h1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in || flush)
    begin
      level <= 11'h0;
      wptr  <= 10'h0;
      rptr  <= 10'h0;
    end
    else
    begin
      level <= next_level;
      if (do_push)
        wptr <= wptr + 10'h1;
      if (do_pop)
        rptr <= rptr + 10'h1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (do_push)
      mem[wptr] <= snap[push_idx];
  end

  // One result is pushed per cycle; an edge during a push is a lost sample
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in || flush)
    begin
      push_left <= 3'h0;
      push_idx  <= 2'h0;
    end
    else if (capture_ev && push_left == 3'h0)
    begin
      for (int k = 0; k < 4; k++)
        snap[k] <= fmt(adc_data_in[16*k +: 16]);
      push_left <= cfg.count;
      push_idx  <= cfg.base;
    end
    else if (push_left != 3'h0 && (do_push || full))
    begin
      push_left <= push_left - 3'h1;
      push_idx  <= push_idx + 2'h1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      hold_out <= 1'b0;
    else
      hold_out <= (capture_ev && push_left == 3'h0) ||
                  (sample_read_cmd && !ext_active && pop_left == 3'h0);
  end

  // --------------------------------------------------------------------------
  // Reads and error flags
  // --------------------------------------------------------------------------
  escap_sample_t result [4];
  logic          err_empty;
  logic          err_ovf;
  logic          empty_set;

  assign empty_set = sample_read_cmd & ext_active & (pop_left == 3'h0) &
                     ({8'h0, need} > level);

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in || flush)
    begin
      pop_left <= 3'h0;
      pop_idx  <= 2'h0;
      if (!reset_n_in)
        for (int k = 0; k < 4; k++)
          result[k] <= 16'h0000;
    end
    else if (pop_left != 3'h0)
    begin
      result[pop_idx] <= mem[rptr];
      pop_left        <= pop_left - 3'h1;
      pop_idx         <= pop_idx + 2'h1;
    end
    else if (sample_read_cmd && ext_active && !empty_set)
    begin
      pop_left <= need;
      pop_idx  <= 2'h0;
    end
    else if (sample_read_cmd && !ext_active)
    begin
      for (int k = 0; k < 4; k++)
        if (k < 32'(cfg.count))
          result[k] <= fmt(adc_data_in[16*(32'(cfg.base) + k) % 64 +: 16]);
    end
  end

  // Set wins over clear on err_empty; flush masks lost, so clear wins on err_ovf
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      err_empty <= 1'b0;
      err_ovf   <= 1'b0;
    end
    else
    begin
      err_empty <= empty_set | (err_empty & ~fifo_clear_cmd);
      err_ovf   <= lost | (err_ovf & ~fifo_clear_cmd);
    end
  end

  // --------------------------------------------------------------------------
  // Read data, captured in the setup phase for a zero-wait access
  // --------------------------------------------------------------------------
  logic [31:0] rdata;

  always_comb
  begin
    rdata = 32'h0;
    case (paddr_in)
      `ESCAP_OFS_CONFIG:
      begin
        rdata[`ESCAP_CFG_COUNT_LSB +: 3] = cfg.count;
        rdata[`ESCAP_CFG_BASE_LSB +: 2]  = cfg.base;
        rdata[`ESCAP_CFG_EXT_BIT]        = cfg.ext_sel;
      end
      `ESCAP_OFS_COUPLING: rdata[9:0] = coupling;
      `ESCAP_OFS_STATUS:
      begin
        rdata[`ESCAP_ST_ARMED_BIT]     = armed;
        rdata[`ESCAP_ST_BUSY_BIT]      = (pop_left != 3'h0);
        rdata[`ESCAP_ST_EMPTY_BIT]     = err_empty;
        rdata[`ESCAP_ST_OVF_BIT]       = err_ovf;
        rdata[`ESCAP_ST_LEVEL_LSB +: 11] = level;
      end
      `ESCAP_OFS_RESULT0: rdata[15:0] = result[0];
      `ESCAP_OFS_RESULT1: rdata[15:0] = result[1];
      `ESCAP_OFS_RESULT2: rdata[15:0] = result[2];
      `ESCAP_OFS_RESULT3: rdata[15:0] = result[3];
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata_out  <= pwrite_in ? 32'h0 : rdata;
      pslverr_out <= ~mapped;
    end
  end

endmodule : escap_top

`default_nettype wire

/* bench/escap_assertions.sv */
// Port assertions for the sample capture block.
// Bound into escap_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module escap_checker
  import escap_pkg::*;
#(
  parameter escap_variant_e VARIANT = ESCAP_V12
)
(
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        ext_sample_clock_n_in,
  input wire logic        bus_clock_input_in,
  input wire logic [63:0] adc_data_in,
  input wire logic        hold_out,
  input wire logic [4:0]  couple_dc_out,
  input wire logic [4:0]  couple_gnd_out
);
  // ----------
  // Helper state
  // ----------
  logic       arm_q;
  logic       ext_q;
  logic       why_q;
  logic [4:0] dc_q;
  wire logic  wr  = psel_in && penable_in && pready_out && pwrite_in;
  wire logic  cmd = wr && paddr_in == 8'h00;
  wire logic  cpl = wr && paddr_in == 8'h08;
  wire logic  on  = arm_q && ext_q && !cmd;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  // Shadow of arm and clock select, so edges can be judged
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      arm_q <= 1'b0;
      ext_q <= 1'b0;
      why_q <= 1'b0;
      dc_q  <= 5'h00;
    end
    else
    begin
      why_q <= $rose(ext_sample_clock_n_in) || $fell(bus_clock_input_in)
               || (cmd && pwdata_in[3]);
      if (cmd && pwdata_in[0]) arm_q <= !pwdata_in[1];
      if (wr && paddr_in == 8'h04) ext_q <= pwdata_in[8];
      if (cpl)
        for (int i = 0; i < 5; i++) dc_q[i] <= pwdata_in[2*i +: 2] == 2'h1;
    end
  end

  chk_gnd_never: assert property (VARIANT != ESCAP_V12 ||
    couple_gnd_out == 5'h00) else $error("ground coupling driven");
  chk_reset_couple: assert property ($rose(reset_n_in) &&
    VARIANT == ESCAP_V12 |=> couple_dc_out == 5'h00)
    else $error("coupling not AC after reset");
  chk_dc_follow: assert property (cpl |-> ##[1:2]
    couple_dc_out == dc_q) else $error("DC coupling mismatch");
  chk_pin_capture: assert property (on &&
    $rose(ext_sample_clock_n_in) |=> hold_out) else $error("pin edge missed");
  chk_bus_capture: assert property (on &&
    $fell(bus_clock_input_in) |=> hold_out) else $error("bus edge missed");
  chk_idle_quiet: assert property (!(arm_q && ext_q) && !cmd &&
    ($rose(ext_sample_clock_n_in) || $fell(bus_clock_input_in))
    |=> !hold_out) else $error("capture while disarmed");
  chk_hold_cause: assert property (hold_out |-> why_q)
    else $error("hold without cause");
  chk_cmd_zero: assert property (psel_in && !penable_in &&
    !pwrite_in && paddr_in == 8'h00 |=> prdata_out == 32'h0)
    else $error("command register read not zero");
endmodule : escap_checker

bind escap_top escap_checker #(.VARIANT(VARIANT)) u_chk (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .ext_sample_clock_n_in(ext_sample_clock_n_in),
  .bus_clock_input_in(bus_clock_input_in), .adc_data_in(adc_data_in),
  .hold_out(hold_out), .couple_dc_out(couple_dc_out),
  .couple_gnd_out(couple_gnd_out)
);
`default_nettype wire

/* bench/escap_source.sv */
// Far side: external pulse source and four converter outputs.
// Assumes one-cycle fire requests on mclk_in.
`timescale 1ns/1ps
`default_nettype none
module escap_source
(
  input  wire logic        mclk_in,
  input  wire logic        fire_in,
  input  wire logic        via_bus_in,
  output logic             ext_sample_clock_n_out,
  output logic             bus_clock_input_out,
  output logic      [63:0] adc_data_out
);
  logic [1:0] left_q = 2'h0;
  logic       bus_q  = 1'b0;
  logic [7:0] seq_q  = 8'h00;

  // Data moves two cycles before the edge, so it is settled
  always_ff @(posedge mclk_in)
  begin
    if (fire_in && left_q == 2'h0)
    begin
      left_q <= 2'h2;
      bus_q  <= via_bus_in;
      seq_q  <= seq_q + 8'h01;
    end
    else if (left_q != 2'h0)
      left_q <= left_q - 2'h1;
  end

  assign ext_sample_clock_n_out = !(left_q != 2'h0 && !bus_q);
  assign bus_clock_input_out    = left_q != 2'h0 && bus_q;

  // Top nibble is junk the 12-bit path must drop
  always_comb
    for (int k = 0; k < 4; k++)
      adc_data_out[16*k +: 16] = {4'hA, 1'b1, seq_q[6:0], k[3:0]};
endmodule : escap_source
`default_nettype wire

/* bench/test_escap_top.sv */
// Self-checking bench for escap_top, 12-bit variant.
// Assumes escap_source on the capture pins and converter data.
`timescale 1ns/1ps
`default_nettype none
module test_escap_top;
  import escap_pkg::*;
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;
  } escap_row_s;
  logic        mclk_in    = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        fire       = 1'b0;
  logic        via_bus    = 1'b0;
  logic [31:0] q;
  logic        perr;
  wire  logic [31:0] prdata;
  wire  logic        pready, pslverr, pin_n, busclk, hold;
  wire  logic [63:0] adc;
  wire  logic [4:0]  dc, gnd;
  int          n_mismatch = 0, check_count = 0, cycles = 0, ev = 0;
  // Coupling row: one code on all inputs, never ground
  escap_row_s  rows [8] = '{
    '{1'b0, 8'h04, 32'h0, 32'h4, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h08, 32'h155, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h155, 1'b0}, '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h06, 32'hFF, 32'h0, 1'b1},
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}};

  escap_top dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .ext_sample_clock_n_in(pin_n),
    .bus_clock_input_in(busclk), .adc_data_in(adc), .hold_out(hold),
    .couple_dc_out(dc), .couple_gnd_out(gnd));
  escap_source u_src (.mclk_in(mclk_in), .fire_in(fire),
    .via_bus_in(via_bus), .ext_sample_clock_n_out(pin_n),
    .bus_clock_input_out(busclk), .adc_data_out(adc));

  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do @(posedge mclk_in); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic st(input logic [31:0] want);
    apb(1'b0, 8'h0C, 32'h0);
    chk(q, want);
  endtask : st
  task automatic res(input int s, input int base, input int n);
    for (int i = 0; i < n; i++)
    begin
      apb(1'b0, 8'(8'h10 + 4 * i), 32'h0);
      chk(q, {16'h0, 4'hF, 1'b1, 7'(s), 4'(base + i)});
    end
  endtask : res
  task automatic rd_ext;
    apb(1'b1, 8'h00, 32'h8);
    do apb(1'b0, 8'h0C, 32'h0); while (q[1] === 1'b1);
  endtask : rd_ext
  // Gap leaves room for a four-result push
  task automatic pulse(input logic bus);
    @(posedge mclk_in);
    fire <= 1'b1;
    via_bus <= bus;
    @(posedge mclk_in);
    fire <= 1'b0;
    ev++;
    repeat (8) @(posedge mclk_in);
  endtask : pulse
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    forever #4 mclk_in = ~mclk_in;
  end
  // Whole run needs about 2900 cycles
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].q);
      chk({31'h0, perr}, {31'h0, rows[i].e});
    end
    chk({27'h0, dc}, 32'h1F);
    chk({27'h0, gnd}, 32'h0);
    $display("test registers done");
    apb(1'b1, 8'h00, 32'h8);
    res(0, 0, 4);
    apb(1'b1, 8'h04, 32'h22);
    apb(1'b1, 8'h00, 32'h8);
    res(0, 2, 2);
    $display("test internal read done");
    apb(1'b1, 8'h04, 32'h104);
    apb(1'b1, 8'h00, 32'h1);
    pulse(1'b0);
    pulse(1'b1);
    st(32'h0008_0001);
    rd_ext();
    res(1, 0, 4);
    rd_ext();
    res(2, 0, 4);
    apb(1'b1, 8'h00, 32'h8);
    st(32'h5);
    res(2, 0, 4);
    apb(1'b1, 8'h00, 32'h4);
    st(32'h1);
    apb(1'b1, 8'h04, 32'h111);
    pulse(1'b0);
    apb(1'b1, 8'h00, 32'h8);
    st(32'h0001_0005);
    pulse(1'b1);
    rd_ext();
    res(ev - 1, 1, 1);
    apb(1'b0, 8'h14, 32'h0);
    chk(q, {16'h0, 4'hF, 1'b1, 7'(ev), 4'h1});
    apb(1'b1, 8'h00, 32'h4);
    pulse(1'b0);
    apb(1'b1, 8'h00, 32'h1);
    st(32'h1);
    $display("test external capture done");
    apb(1'b1, 8'h04, 32'h104);
    repeat (257) pulse(ev[0]);
    st(32'h0400_0009);
    rd_ext();
    st(32'h03FC_0009);
    res(ev - 256, 0, 4);
    apb(1'b1, 8'h00, 32'h4);
    st(32'h1);
    $display("test overflow done");
    apb(1'b1, 8'h00, 32'h3);
    pulse(1'b0);
    pulse(1'b1);
    st(32'h0);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h00, 32'h8);
    res(ev, 0, 4);
    apb(1'b1, 8'h04, 32'h21);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h4);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    st(32'h0);
    $display("test disarm and reset done");
    report_and_stop();
  end
endmodule : test_escap_top
`default_nettype wire
